// >>> pkg/mtrb_pkg.sv
package mtrb_pkg;
    // Clock and timing
    localparam int CLK_KHZ   = 200000;
    localparam int T_POR_MS  = 10;
    localparam int T_MAN_MS  = 5;
    localparam int POR_CYC   = T_POR_MS * CLK_KHZ;
    localparam int MAN_CYC   = T_MAN_MS * CLK_KHZ;
    localparam int CNT_W     = 21;
    localparam int CLK_HALF  = 4;
    localparam int DIV_W     = 8;
    localparam int GAIN_W    = 3;
    localparam int EST_W     = 20;
    localparam int ADDR_W    = 7;

    // Register offsets
    localparam logic [6:0] A_CFG3   = 7'h26;
    localparam logic [6:0] A_TRIM   = 7'h27;
    localparam logic [6:0] A_EST_H  = 7'h28;
    localparam logic [6:0] A_EST_M  = 7'h29;
    localparam logic [6:0] A_EST_L  = 7'h2A;
    localparam logic [6:0] A_LEVEL  = 7'h2C;
    localparam logic [6:0] A_DTUNE  = 7'h31;
    localparam logic [6:0] A_IQ     = 7'h33;
    localparam logic [6:0] A_DLEVEL = 7'h37;
    localparam logic [6:0] A_MARKER = 7'h39;

    // Field positions
    localparam int CFG3_LDRO   = 3;
    localparam int CFG3_AGC    = 2;
    localparam int CFG3_RSV_HI = 1;
    localparam int DTUNE_HI    = 2;
    localparam int DTUNE_RSV_LO = 3;
    localparam int IQ_TOP      = 7;
    localparam int IQ_SWAP     = 6;
    localparam int IQ_RSV_HI   = 5;
    localparam int EST_H_LO    = 16;
    localparam int EST_M_LO    = 8;

    // Reset and fixed values
    localparam logic [7:0] RST_TRIM     = 8'h00;
    localparam logic [2:0] RST_DTUNE    = 3'h3;
    localparam logic [7:0] DTUNE_RSV_RD = 8'hC0;
    localparam logic [5:0] RST_IQ_RSV   = 6'h27;
    localparam logic [7:0] RST_DLEVEL   = 8'h0A;
    localparam logic [7:0] RST_MARKER   = 8'h12;
    localparam logic [7:0] RD_ZERO      = 8'h00;
    localparam logic [3:0] NIB_ZERO     = 4'h0;
    localparam logic [3:0] SF_MIN       = 4'h6;
    localparam logic [3:0] SF_MAX       = 4'hC;
    localparam logic [2:0] LAST_BIT     = 3'h7;
endpackage

// >>> pkg/mtrb_bus_if.sv
`timescale 1ns/100ps
interface mtrb_bus_if;
    logic [6:0] addr;
    logic [6:0] waddr;
    logic [7:0] wdata;
    logic       wr_stb;
    logic [7:0] rdata;
    modport slave (output addr, output waddr, output wdata, output wr_stb, input rdata);
    modport bank  (input addr, input waddr, input wdata, input wr_stb, output rdata);
endinterface

// >>> rtl/mtrb_spi_slave.sv
`timescale 1ns/100ps
module mtrb_spi_slave (
    input  wire logic     clk,
    input  wire logic     arst_n,
    input  wire logic     en,
    input  wire logic     sck_pin,
    input  wire logic     nss_n_pin,
    input  wire logic     mosi_pin,
    output logic          miso,
    output logic          miso_oe,
    mtrb_bus_if.slave     bus
);
    typedef struct packed {
        logic       sck_s1;
        logic       sck_s2;
        logic       sck_s3;
        logic       nss_s1;
        logic       nss_s2;
        logic       mosi_s1;
        logic       mosi_s2;
        logic [2:0] bitcnt;
        logic       first;
        logic       write;
        logic [6:0] addr;
        logic [6:0] waddr;
        logic [7:0] shin;
        logic [7:0] wdata;
        logic       wr;
        logic       load;
        logic [7:0] tx;
        logic       miso;
        logic       oe;
    } mtrb_spi_s;

    localparam mtrb_spi_s ST_RST = '{nss_s1: 1'b1, nss_s2: 1'b1, first: 1'b1, default: '0};

    mtrb_spi_s r_r;
    mtrb_spi_s r_nxt;

    always_comb begin
        logic rise;
        logic fall;
        rise = 1'b0;
        fall = 1'b0;
        r_nxt = r_r;
        r_nxt.wr = 1'b0;
        r_nxt.load = 1'b0;
        r_nxt.sck_s1 = sck_pin;
        r_nxt.sck_s2 = r_r.sck_s1;
        r_nxt.sck_s3 = r_r.sck_s2;
        r_nxt.nss_s1 = nss_n_pin;
        r_nxt.nss_s2 = r_r.nss_s1;
        r_nxt.mosi_s1 = mosi_pin;
        r_nxt.mosi_s2 = r_r.mosi_s1;
        rise = r_r.sck_s2 & ~r_r.sck_s3;
        fall = ~r_r.sck_s2 & r_r.sck_s3;
        if (r_r.load) begin
            r_nxt.tx = bus.rdata;
        end
        if (r_r.nss_s2) begin
            r_nxt.bitcnt = '0;
            r_nxt.first = 1'b1;
            r_nxt.oe = 1'b0;
            r_nxt.miso = 1'b0;
        end else begin
            r_nxt.oe = 1'b1;
            if (rise) begin
                r_nxt.shin = {r_r.shin[6:0], r_r.mosi_s2};
                r_nxt.bitcnt = r_r.bitcnt + 3'h1;
                if (r_r.bitcnt == mtrb_pkg::LAST_BIT) begin
                    if (r_r.first) begin
                        // Address byte: top bit selects write
                        r_nxt.first = 1'b0;
                        r_nxt.write = r_r.shin[6];
                        r_nxt.addr = {r_r.shin[5:0], r_r.mosi_s2};
                        r_nxt.load = ~r_r.shin[6];
                    end else begin
                        // Data byte: write strobe, then burst increment
                        r_nxt.wr = r_r.write;
                        r_nxt.waddr = r_r.addr;
                        r_nxt.wdata = {r_r.shin[6:0], r_r.mosi_s2};
                        r_nxt.addr = r_r.addr + 7'h01;
                        r_nxt.load = ~r_r.write;
                    end
                end
            end
            if (fall) begin
                r_nxt.miso = r_r.tx[7];
                r_nxt.tx = {r_r.tx[6:0], 1'b0};
            end
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            r_r <= ST_RST;
        end else if (en) begin
            r_r <= r_nxt;
        end
    end

    assign bus.addr = r_r.addr;
    assign bus.waddr = r_r.waddr;
    assign bus.wdata = r_r.wdata;
    assign bus.wr_stb = r_r.wr;
    assign miso = r_r.miso;
    assign miso_oe = r_r.oe;
endmodule

// >>> rtl/mtrb_regs.sv
`timescale 1ns/100ps
// Overview of operation
// - Gain select picks manual or loop gain
// - Rate trim register, read/write, resets zero
// - Read-only 20-bit carrier offset over three bytes
// - Read-only wideband signal level for entropy
// - Quadrature swap bit inverts I and Q
// - Network marker resets 0x12; avoid 0x34
// - Power-on reset needs no host action
// - Derived clock toggles only once ready
// - Spreading factor 6 to 12, others reserved
module mtrb_regs #(
    parameter int POR_READY_CYC = mtrb_pkg::POR_CYC,
    parameter int MAN_READY_CYC = mtrb_pkg::MAN_CYC,
    parameter int DERIVED_CLOCK_OUTPUT_HALF   = mtrb_pkg::CLK_HALF,
    parameter int GAIN_W        = mtrb_pkg::GAIN_W
) (
    input  wire logic                        SYS_CLK,
    input  wire logic                        ARST_N,
    input  wire logic                        CLK_EN,
    input  wire logic                        SPI_SCK,
    input  wire logic                        SPI_NSS_N,
    input  wire logic                        SPI_MOSI,
    output logic                             SPI_MISO,
    output logic                             SPI_MISO_OE,
    input  wire logic                        RESET_IN_N,
    input  wire logic [mtrb_pkg::EST_W-1:0]  CARRIER_OFFSET_ESTIMATE,
    input  wire logic [7:0]                  BROADBAND_SIGNAL_LEVEL,
    input  wire logic [GAIN_W-1:0]           AGC_LOOP_GAIN,
    input  wire logic [GAIN_W-1:0]           MANUAL_GAIN_VALUE,
    input  wire logic [3:0]                  CHIPS_PER_SYMBOL_LOG,
    output logic                             LONG_SYMBOL_TUNING,
    output logic                             AUTO_GAIN_SELECT,
    output logic [GAIN_W-1:0]                LNA_GAIN,
    output logic [7:0]                       RATE_OFFSET_TRIM,
    output logic [2:0]                       DETECT_TUNING_CODE,
    output logic                             QUADRATURE_SWAP,
    output logic [7:0]                       DETECT_LEVEL_CODE,
    output logic [7:0]                       NETWORK_MARKER,
    output logic                             SF_RESERVED,
    output logic                             DEVICE_READY,
    output logic                             DERIVED_CLOCK_OUTPUT
);
    localparam int CW = mtrb_pkg::CNT_W;
    localparam int DW = mtrb_pkg::DIV_W;

    typedef struct packed {
        logic              rstn_s1;
        logic              rstn_s2;
        logic              por;
        logic [CW-1:0]     cnt;
        logic              ready;
        logic [DW-1:0]     div;
        logic              derived_clock_output;
        logic              ldro;
        logic              agc;
        logic [1:0]        cfg3_rsv;
        logic [7:0]        trim;
        logic [2:0]        dtune;
        logic              iq_top;
        logic              iq_swap;
        logic [5:0]        iq_rsv;
        logic [7:0]        dlevel;
        logic [7:0]        marker;
        logic [GAIN_W-1:0] lna;
        logic              sf_rsv;
    } mtrb_state_s;

    localparam mtrb_state_s ST_RST = '{
        rstn_s1: 1'b1, rstn_s2: 1'b1, por: 1'b1,
        trim:    mtrb_pkg::RST_TRIM,
        dtune:   mtrb_pkg::RST_DTUNE,
        iq_rsv:  mtrb_pkg::RST_IQ_RSV,
        dlevel:  mtrb_pkg::RST_DLEVEL,
        marker:  mtrb_pkg::RST_MARKER,
        default: '0
    };

    mtrb_state_s r_r;
    mtrb_state_s r_nxt;
    mtrb_bus_if  bus ();

    mtrb_spi_slave u_spi (
        .clk       (SYS_CLK),
        .arst_n    (ARST_N),
        .en        (CLK_EN),
        .sck_pin   (SPI_SCK),
        .nss_n_pin (SPI_NSS_N),
        .mosi_pin  (SPI_MOSI),
        .miso      (SPI_MISO),
        .miso_oe   (SPI_MISO_OE),
        .bus       (bus.slave)
    );

    // Read data mux
    always_comb begin
        case (bus.addr)
            mtrb_pkg::A_CFG3:   bus.rdata = {mtrb_pkg::NIB_ZERO, r_r.ldro, r_r.agc,
                                             r_r.cfg3_rsv};
            mtrb_pkg::A_TRIM:   bus.rdata = r_r.trim;
            mtrb_pkg::A_EST_H:  bus.rdata = {mtrb_pkg::NIB_ZERO,
                CARRIER_OFFSET_ESTIMATE[mtrb_pkg::EST_W-1:mtrb_pkg::EST_H_LO]};
            mtrb_pkg::A_EST_M:  bus.rdata =
                CARRIER_OFFSET_ESTIMATE[mtrb_pkg::EST_H_LO-1:mtrb_pkg::EST_M_LO];
            mtrb_pkg::A_EST_L:  bus.rdata =
                CARRIER_OFFSET_ESTIMATE[mtrb_pkg::EST_M_LO-1:0];
            mtrb_pkg::A_LEVEL:  bus.rdata = BROADBAND_SIGNAL_LEVEL;
            mtrb_pkg::A_DTUNE:  bus.rdata = {mtrb_pkg::DTUNE_RSV_RD[7:mtrb_pkg::DTUNE_RSV_LO],
                                             r_r.dtune};
            mtrb_pkg::A_IQ:     bus.rdata = {r_r.iq_top, r_r.iq_swap, r_r.iq_rsv};
            mtrb_pkg::A_DLEVEL: bus.rdata = r_r.dlevel;
            mtrb_pkg::A_MARKER: bus.rdata = r_r.marker;
            default:            bus.rdata = mtrb_pkg::RD_ZERO;
        endcase
    end

    // Next state
    always_comb begin
        r_nxt = r_r;
        r_nxt.rstn_s1 = RESET_IN_N;
        r_nxt.rstn_s2 = r_r.rstn_s1;
        r_nxt.lna = r_r.agc ? AGC_LOOP_GAIN : MANUAL_GAIN_VALUE;
        r_nxt.sf_rsv = (CHIPS_PER_SYMBOL_LOG < mtrb_pkg::SF_MIN) ||
                       (CHIPS_PER_SYMBOL_LOG > mtrb_pkg::SF_MAX);
        if (!r_r.rstn_s2) begin
            // Manual reset held: bank to reset values, ready dropped
            r_nxt = ST_RST;
            r_nxt.rstn_s1 = RESET_IN_N;
            r_nxt.rstn_s2 = r_r.rstn_s1;
            r_nxt.por = 1'b0;
            r_nxt.lna = r_r.lna;
            r_nxt.sf_rsv = r_r.sf_rsv;
        end else begin
            if (!r_r.ready) begin
                // Startup wait, longer after power-on
                if (r_r.cnt == (r_r.por ? CW'(POR_READY_CYC - 1)
                                        : CW'(MAN_READY_CYC - 1))) begin
                    r_nxt.ready = 1'b1;
                end else begin
                    r_nxt.cnt = r_r.cnt + CW'(1);
                end
            end else if (r_r.div == DW'(DERIVED_CLOCK_OUTPUT_HALF - 1)) begin
                r_nxt.div = '0;
                r_nxt.derived_clock_output = ~r_r.derived_clock_output;
            end else begin
                r_nxt.div = r_r.div + DW'(1);
            end
            if (bus.wr_stb) begin
                case (bus.waddr)
                    mtrb_pkg::A_CFG3: begin
                        r_nxt.ldro = bus.wdata[mtrb_pkg::CFG3_LDRO];
                        r_nxt.agc = bus.wdata[mtrb_pkg::CFG3_AGC];
                        r_nxt.cfg3_rsv = bus.wdata[mtrb_pkg::CFG3_RSV_HI:0];
                    end
                    mtrb_pkg::A_TRIM: begin
                        r_nxt.trim = bus.wdata;
                    end
                    mtrb_pkg::A_DTUNE: begin
                        r_nxt.dtune = bus.wdata[mtrb_pkg::DTUNE_HI:0];
                    end
                    mtrb_pkg::A_IQ: begin
                        r_nxt.iq_top = bus.wdata[mtrb_pkg::IQ_TOP];
                        r_nxt.iq_swap = bus.wdata[mtrb_pkg::IQ_SWAP];
                        r_nxt.iq_rsv = bus.wdata[mtrb_pkg::IQ_RSV_HI:0];
                    end
                    mtrb_pkg::A_DLEVEL: begin
                        r_nxt.dlevel = bus.wdata;
                    end
                    mtrb_pkg::A_MARKER: begin
                        r_nxt.marker = bus.wdata;
                    end
                    default: begin
                        r_nxt.marker = r_r.marker;
                    end
                endcase
            end
        end
    end

    // Power-on reset comes in on the async reset
    always_ff @(posedge SYS_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            r_r <= ST_RST;
        end else if (CLK_EN) begin
            r_r <= r_nxt;
        end
    end

    assign LONG_SYMBOL_TUNING = r_r.ldro;
    assign AUTO_GAIN_SELECT = r_r.agc;
    assign LNA_GAIN = r_r.lna;
    assign RATE_OFFSET_TRIM = r_r.trim;
    assign DETECT_TUNING_CODE = r_r.dtune;
    assign QUADRATURE_SWAP = r_r.iq_swap;
    assign DETECT_LEVEL_CODE = r_r.dlevel;
    assign NETWORK_MARKER = r_r.marker;
    assign SF_RESERVED = r_r.sf_rsv;
    assign DEVICE_READY = r_r.ready;
    assign DERIVED_CLOCK_OUTPUT = r_r.derived_clock_output;

    // Checks
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (!ARST_N);

    AST_GAIN_MANUAL: assert property (ARST_N && CLK_EN && r_r.rstn_s2 && !r_r.agc |=>
        LNA_GAIN == $past(MANUAL_GAIN_VALUE))
        else $error("manual gain not applied");
    AST_GAIN_AUTO: assert property (ARST_N && CLK_EN && r_r.rstn_s2 && r_r.agc |=>
        LNA_GAIN == $past(AGC_LOOP_GAIN))
        else $error("loop gain not applied");
    AST_TRIM_WRITE: assert property (CLK_EN && r_r.rstn_s2 && bus.wr_stb &&
        bus.waddr == mtrb_pkg::A_TRIM |=> RATE_OFFSET_TRIM == $past(bus.wdata))
        else $error("trim write lost");
    AST_EST_HIGH: assert property (bus.addr == mtrb_pkg::A_EST_H |->
        bus.rdata == {mtrb_pkg::NIB_ZERO, CARRIER_OFFSET_ESTIMATE[19:16]})
        else $error("offset high byte wrong");
    AST_LEVEL_READ: assert property (bus.addr == mtrb_pkg::A_LEVEL |->
        bus.rdata == BROADBAND_SIGNAL_LEVEL)
        else $error("signal level read wrong");
    AST_SWAP_WRITE: assert property (CLK_EN && r_r.rstn_s2 && bus.wr_stb &&
        bus.waddr == mtrb_pkg::A_IQ |=> QUADRATURE_SWAP == $past(bus.wdata[6]))
        else $error("swap bit write lost");
    AST_CFG3_TOP: assert property (bus.addr == mtrb_pkg::A_CFG3 |->
        bus.rdata[7:4] == mtrb_pkg::NIB_ZERO)
        else $error("config upper bits not zero");
    AST_MAN_RESET: assert property (CLK_EN && !r_r.rstn_s2 |=>
        NETWORK_MARKER == mtrb_pkg::RST_MARKER && DETECT_LEVEL_CODE == mtrb_pkg::RST_DLEVEL &&
        !DEVICE_READY)
        else $error("manual reset incomplete");
    AST_CLK_QUIET: assert property (!DEVICE_READY |-> !DERIVED_CLOCK_OUTPUT)
        else $error("derived clock active before ready");
    AST_SF_FLAG: assert property (ARST_N && CLK_EN && r_r.rstn_s2 &&
        CHIPS_PER_SYMBOL_LOG == 4'hD |=> SF_RESERVED)
        else $error("reserved spreading factor not flagged");

    COV_TRIM_WRITE: cover property (bus.wr_stb && bus.waddr == mtrb_pkg::A_TRIM);
    COV_MAN_RESET: cover property ($fell(r_r.rstn_s2));
    COV_READY: cover property ($rose(DEVICE_READY));
    COV_DERIVED_CLOCK_OUTPUT: cover property ($rose(DERIVED_CLOCK_OUTPUT));
endmodule

// >>> test/mtrb_host_model.sv
`timescale 1ns/100ps
module mtrb_host_model #(
    parameter int PH = 6
) (
    input  wire logic       clk,
    input  wire logic       miso,
    output logic            sck,
    output logic            nss_n,
    output logic            mosi,
    output logic [7:0]      rd_data,
    output logic            rd_vld
);
    initial begin
        sck = 1'b0;
        nss_n = 1'b1;
        mosi = 1'b0;
        rd_data = 8'h00;
        rd_vld = 1'b0;
    end

    // One command byte and one data byte, mode 0, MSB first
    task automatic xfer(input logic [7:0] cmd, input logic [7:0] wd);
        logic [15:0] sh;
        sh = {cmd, wd};
        @(posedge clk);
        nss_n <= 1'b0;
        for (int i = 15; i >= 0; i--) begin
            mosi <= sh[i];
            repeat (PH) @(posedge clk);
            if (i < 8) begin
                rd_data[i] <= miso;
            end
            sck <= 1'b1;
            repeat (PH) @(posedge clk);
            sck <= 1'b0;
        end
        repeat (PH) @(posedge clk);
        nss_n <= 1'b1;
        mosi <= ~mosi;
        rd_vld <= ~cmd[7];
        @(posedge clk);
        rd_vld <= 1'b0;
        repeat (PH) @(posedge clk);
    endtask
endmodule

// >>> test/tb_top.sv
`timescale 1ns/100ps
module tb_top;
    localparam int POR_N = 20;
    localparam int MAN_N = 10;
    localparam int HALF  = 4;
    localparam int LIMIT = 30000;
    logic        clk, arst_n, rst_in_n, sck, nss_n, mosi, miso, miso_oe;
    logic [19:0] est;
    logic [7:0]  level, trim, dlevel, marker, rd_data, v;
    logic [2:0]  agc_g, man_g, lna, dtune;
    logic [3:0]  sf;
    logic        lst, ags, qswap, sf_rsv, ready, dclk, rd_vld, d0, clk_en;
    int          failures, total_checks, cycles, seed;
    logic [7:0]  exp_q[$];

    mtrb_regs #(.POR_READY_CYC(POR_N), .MAN_READY_CYC(MAN_N), .DERIVED_CLOCK_OUTPUT_HALF(HALF)) mtrb_regs_i (
        .SYS_CLK                 (clk),
        .ARST_N                  (arst_n),
        .CLK_EN                  (clk_en),
        .SPI_SCK                 (sck),
        .SPI_NSS_N               (nss_n),
        .SPI_MOSI                (mosi),
        .SPI_MISO                (miso),
        .SPI_MISO_OE             (miso_oe),
        .RESET_IN_N              (rst_in_n),
        .CARRIER_OFFSET_ESTIMATE (est),
        .BROADBAND_SIGNAL_LEVEL  (level),
        .AGC_LOOP_GAIN           (agc_g),
        .MANUAL_GAIN_VALUE       (man_g),
        .CHIPS_PER_SYMBOL_LOG    (sf),
        .LONG_SYMBOL_TUNING      (lst),
        .AUTO_GAIN_SELECT        (ags),
        .LNA_GAIN                (lna),
        .RATE_OFFSET_TRIM        (trim),
        .DETECT_TUNING_CODE      (dtune),
        .QUADRATURE_SWAP         (qswap),
        .DETECT_LEVEL_CODE       (dlevel),
        .NETWORK_MARKER          (marker),
        .SF_RESERVED             (sf_rsv),
        .DEVICE_READY            (ready),
        .DERIVED_CLOCK_OUTPUT    (dclk)
    );

    mtrb_host_model mtrb_host_model_i (
        .clk     (clk),
        .miso    (miso),
        .sck     (sck),
        .nss_n   (nss_n),
        .mosi    (mosi),
        .rd_data (rd_data),
        .rd_vld  (rd_vld)
    );

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    task automatic end_sim();
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic chk_port(input logic [7:0] got, input logic [7:0] exp, input string what);
        total_checks++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] %0t port %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    task automatic chk_rd(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] %0t read got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic rd(input logic [6:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        mtrb_host_model_i.xfer({1'b0, a}, 8'h00);
    endtask

    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        mtrb_host_model_i.xfer({1'b1, a}, d);
    endtask

    task automatic wait_ready(input int lim);
        int n;
        n = 0;
        while (ready !== 1'b1 && n < lim) begin
            @(posedge clk);
            n++;
        end
        chk_port({7'h00, ready}, 8'h01, "ready");
    endtask

    task automatic chk_defaults();
        rd(mtrb_pkg::A_CFG3, 8'h00);
        rd(mtrb_pkg::A_TRIM, 8'h00);
        rd(mtrb_pkg::A_DTUNE, 8'hC3);
        rd(mtrb_pkg::A_IQ, 8'h27);
        rd(mtrb_pkg::A_DLEVEL, 8'h0A);
        rd(mtrb_pkg::A_MARKER, 8'h12);
        rd(7'h2B, 8'h00);
        chk_port(marker, 8'h12, "marker");
        chk_port({5'h00, dtune}, 8'h03, "tune");
        chk_port({6'h00, qswap, lst}, 8'h00, "swap");
    endtask

    always @(posedge clk) begin
        if (rd_vld === 1'b1) begin
            chk_rd(rd_data, (exp_q.size() > 0) ? exp_q.pop_front() : 8'hxx);
            chk_port({7'h00, miso_oe}, 8'h01, "miso oe");
        end
    end

    always @(posedge clk) begin
        cycles++;
        if (cycles == LIMIT) begin
            failures++;
            $display("[FAIL] %0t timeout", $time);
            end_sim();
        end
    end

    initial begin
        seed = 35258;
        clk_en = 1'b1;
        arst_n = 1'b0;
        rst_in_n = 1'b1; // Held inactive through power-on
        est = 20'h0_0000;
        level = 8'h00;
        agc_g = 3'h0;
        man_g = 3'h0;
        sf = 4'h7;
        repeat (2) @(posedge clk);
        chk_port({5'h00, miso_oe, ready, dclk}, 8'h00, "por");
        arst_n <= 1'b1;
        wait_ready(POR_N + 10);
        chk_defaults();
        $display("test defaults done");
        @(posedge clk);
        est <= 20'($random(seed));
        @(posedge clk);
        rd(mtrb_pkg::A_EST_H, {4'h0, est[19:16]});
        rd(mtrb_pkg::A_EST_M, est[15:8]);
        wr(mtrb_pkg::A_EST_L, ~est[7:0]);
        rd(mtrb_pkg::A_EST_L, est[7:0]);
        for (int i = 0; i < 2; i++) begin
            level <= 8'($random(seed));
            @(posedge clk);
            rd(mtrb_pkg::A_LEVEL, level);
        end
        $display("test readback done");
        v = 8'($random(seed));
        wr(mtrb_pkg::A_TRIM, v);
        rd(mtrb_pkg::A_TRIM, v);
        chk_port(trim, v, "trim");
        v = 8'($random(seed));
        agc_g <= v[2:0];
        man_g <= ~v[2:0];
        wr(mtrb_pkg::A_CFG3, 8'hFF);
        rd(mtrb_pkg::A_CFG3, 8'h0F);
        chk_port({6'h00, lst, ags}, 8'h03, "cfg");
        chk_port({5'h00, lna}, {5'h00, agc_g}, "gain auto");
        wr(mtrb_pkg::A_CFG3, 8'h08);
        chk_port({5'h00, lna}, {5'h00, man_g}, "gain man");
        sf <= 4'h6;
        wr(mtrb_pkg::A_DTUNE, 8'h05);
        rd(mtrb_pkg::A_DTUNE, 8'hC5);
        chk_port({5'h00, dtune}, 8'h05, "tune");
        wr(mtrb_pkg::A_DLEVEL, 8'h0C);
        chk_port(dlevel, 8'h0C, "level");
        rd(mtrb_pkg::A_IQ, 8'h27);
        wr(mtrb_pkg::A_IQ, 8'h67);
        rd(mtrb_pkg::A_IQ, 8'h67);
        chk_port({7'h00, qswap}, 8'h01, "swap");
        wr(mtrb_pkg::A_MARKER, 8'h55);
        rd(mtrb_pkg::A_MARKER, 8'h55);
        chk_port(marker, 8'h55, "marker");
        $display("test writes done");
        for (int i = 0; i < 16; i++) begin
            sf <= 4'(i);
            repeat (3) @(posedge clk);
            chk_port({7'h00, sf_rsv}, {7'h00, (i < 6 || i > 12)}, "sf");
        end
        $display("test spreading factor done");
        rst_in_n <= 1'b0;
        repeat (20) @(posedge clk);
        chk_port({6'h00, ready, dclk}, 8'h00, "man rst");
        rst_in_n <= 1'b1;
        wait_ready(MAN_N + 10);
        chk_defaults();
        d0 = dclk;
        repeat (HALF) @(posedge clk);
        chk_port({7'h00, dclk}, {7'h00, ~d0}, "derived_clock_output");
        clk_en <= 1'b0;
        @(posedge clk);
        d0 = dclk;
        repeat (2 * HALF) @(posedge clk);
        chk_port({7'h00, dclk}, {7'h00, d0}, "freeze");
        clk_en <= 1'b1;
        $display("test manual reset done");
        wr(mtrb_pkg::A_TRIM, 8'h5A);
        chk_port(trim, 8'h5A, "trim");
        arst_n <= 1'b0;
        repeat (2) @(posedge clk);
        chk_port(trim, 8'h00, "trim por");
        arst_n <= 1'b1;
        wait_ready(POR_N + 10);
        rd(mtrb_pkg::A_TRIM, 8'h00);
        $display("test second power-on done");
        repeat (20) @(posedge clk);
        end_sim();
    end
endmodule
